// File: pkg/sgc_defs.svh
`ifndef SGC_DEFS_SVH
`define SGC_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define SGC_OFS_FAMILY   8'h00
`define SGC_OFS_ID_RUN   8'h01
`define SGC_OFS_GCTL0    8'h02
// ****************************************
// Field positions
// ****************************************
`define SGC_RUN_BIT      0
`define SGC_BACKOFF_BIT  7
`define SGC_SRST_BIT     6
`define SGC_FLDYN_BIT    5
`define SGC_FLSTA_BIT    4
`define SGC_DROPSEL_BIT  1
`define SGC_LNKAGE_BIT   0
// ****************************************
// Reset values
// ****************************************
`define SGC_RUN_RST      1'b1
`define SGC_RSVD_RST     2'h3
// ****************************************
// Serial port commands
// ****************************************
`define SGC_CMD_WRITE    8'h02
`define SGC_CMD_READ     8'h03
// ****************************************
// Frame match values and timing
// ****************************************
`define SGC_PAUSE_TYPE   16'h8808
`define SGC_PAUSE_DA     48'h0180C2000001
`define SGC_CLK_MHZ      50
`define SGC_FAST_AGE_US  800
`define SGC_FAST_AGE_CYC (`SGC_FAST_AGE_US * `SGC_CLK_MHZ)
`endif

// File: pkg/sgc_pkg.sv
package sgc_pkg;
  // Serial pins after the pad, before synchronising
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } sgc_spi_in_t;

  // One classified received frame header
  typedef struct packed {
    logic        valid;
    logic [15:0] type_len;
    logic [47:0] dest;
    logic        is_flow_ctl;
  } sgc_frame_t;
endpackage : sgc_pkg

// File: hw/sgc_regs.sv
`timescale 1ns/10ps
`include "sgc_defs.svh"
// Contract
// - Run bit starts or halts switching, resets 1
// - Bit 7 selects alternative back-off algorithm
// - Bit 6 resets state machines, data path
// - Soft reset leaves configuration registers unchanged
// - Soft reset stops accepting incoming frames
// - Bit 5 starts learned-table flush, self-clears
// - Flush only ports with learning disabled
// - Bit 4 triggers static-table matching flush
// - Bit 1 set drops 0x8808 or pause DA
// - Bit 1 clear drops flow-control frames only
// - Link loss gives one fast age cycle
// - Unplugged port ages out all learned addresses
module sgc_regs #(
  parameter int          PORTS        = 4,
  parameter int          FAST_AGE_CYC = `SGC_FAST_AGE_CYC,
  parameter logic [7:0]  FAMILY_CODE  = 8'h5A, // Arbitrary value
  parameter logic [3:0]  PART_CODE    = 4'hA,  // Arbitrary value
  parameter logic [2:0]  REV_CODE     = 3'h1   // Arbitrary value
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  // Serial register port
  input  wire sgc_pkg::sgc_spi_in_t spi_in,
  output logic                     spi_miso,
  output logic                     spi_miso_oe,
  // Port status
  input  wire logic [PORTS-1:0]    link_up,
  input  wire logic [PORTS-1:0]    learn_disable,
  // Frame classifier
  input  wire sgc_pkg::sgc_frame_t frame_in,
  output logic                     frame_drop,
  // Switch controls
  output logic                     switch_run,
  output logic                     interop_backoff,
  output logic                     soft_reset,
  output logic                     rx_accept,
  output logic                     flush_learned,
  output logic [PORTS-1:0]         flush_port_mask,
  output logic                     flush_all,
  output logic                     flush_static,
  output logic                     interop_drop_select,
  output logic                     fast_age,
  output logic                     age_all
);
  import sgc_pkg::*;

  localparam int CW = $clog2(FAST_AGE_CYC + 1);

  // ****************************************
  // Pin synchroniser
  // ****************************************
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  logic [2:0] pin_s3_q;
  logic [2:0] pin_lv_q;
  logic [2:0] pin_lv_d;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      // Idle levels, so no false clock edge follows reset
      pin_s1_q <= 3'h4;
      pin_s2_q <= 3'h4;
      pin_s3_q <= 3'h4;
      pin_lv_q <= 3'h4;
    end
    else if (clk_en)
    begin
      pin_s1_q <= {spi_in.cs_n, spi_in.sck, spi_in.mosi};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      pin_lv_q <= pin_lv_d;
    end
  end

  // A change counts only once two stages agree
  always_comb
  begin
    for (int i = 0; i < 3; i++)
      pin_lv_d[i] = (pin_s2_q[i] == pin_s3_q[i]) ? pin_s3_q[i] : pin_lv_q[i];
  end

  logic sel;
  logic sck_rise;
  logic sck_fall;
  assign sel      = ~pin_lv_d[2];
  assign sck_rise = pin_lv_d[1] & ~pin_lv_q[1];
  assign sck_fall = ~pin_lv_d[1] & pin_lv_q[1];

  // ****************************************
  // Register storage
  // ****************************************
  logic       run_q;
  logic       backoff_q;
  logic       srst_q;
  logic       fldyn_q;
  logic       flsta_q;
  logic       dropsel_q;
  logic       lnkage_q;
  logic       wr_stb_q;
  logic [7:0] wr_addr_q;
  logic [7:0] wr_data_q;

  function automatic logic [7:0] reg_read(input logic [7:0] a);
    if (a == `SGC_OFS_FAMILY)
      reg_read = FAMILY_CODE;
    else if (a == `SGC_OFS_ID_RUN)
      reg_read = {PART_CODE, REV_CODE, run_q};
    else if (a == `SGC_OFS_GCTL0)
      reg_read = {backoff_q, srst_q, fldyn_q, flsta_q, `SGC_RSVD_RST,
                  dropsel_q, lnkage_q};
    else
      reg_read = 8'h00;
  endfunction : reg_read

  // Soft reset never touches this block
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      run_q     <= `SGC_RUN_RST;
      backoff_q <= 1'b0;
      srst_q    <= 1'b0;
      dropsel_q <= 1'b0;
      lnkage_q  <= 1'b0;
    end
    else if (clk_en && wr_stb_q)
    begin
      if (wr_addr_q == `SGC_OFS_ID_RUN)
        run_q <= wr_data_q[`SGC_RUN_BIT];
      else if (wr_addr_q == `SGC_OFS_GCTL0)
      begin
        backoff_q <= wr_data_q[`SGC_BACKOFF_BIT];
        srst_q    <= wr_data_q[`SGC_SRST_BIT];
        dropsel_q <= wr_data_q[`SGC_DROPSEL_BIT];
        lnkage_q  <= wr_data_q[`SGC_LNKAGE_BIT];
      end
    end
  end

  // Flush triggers self-clear one cycle after the write
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      fldyn_q <= 1'b0;
      flsta_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (wr_stb_q && wr_addr_q == `SGC_OFS_GCTL0)
      begin
        fldyn_q <= wr_data_q[`SGC_FLDYN_BIT];
        flsta_q <= wr_data_q[`SGC_FLSTA_BIT];
      end
      else
      begin
        fldyn_q <= 1'b0;
        flsta_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // Serial port slave
  // ****************************************
  logic [2:0] bit_cnt_q;
  logic [1:0] byte_cnt_q;
  logic [7:0] cmd_q;
  logic [7:0] addr_q;
  logic [7:0] rx_sh_q;
  logic [7:0] tx_sh_q;
  logic [7:0] rx_byte;
  assign rx_byte = {rx_sh_q[6:0], pin_lv_d[0]};

  // Linear byte space, unmapped addresses read zero
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      bit_cnt_q   <= 3'h0;
      byte_cnt_q  <= 2'h0;
      cmd_q       <= 8'h00;
      addr_q      <= 8'h00;
      rx_sh_q     <= 8'h00;
      tx_sh_q     <= 8'h00;
      wr_stb_q    <= 1'b0;
      wr_addr_q   <= 8'h00;
      wr_data_q   <= 8'h00;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_stb_q    <= 1'b0;
      spi_miso_oe <= sel;
      if (!sel)
      begin
        bit_cnt_q  <= 3'h0;
        byte_cnt_q <= 2'h0;
      end
      else if (sck_rise)
      begin
        rx_sh_q   <= rx_byte;
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7)
        begin
          if (byte_cnt_q != 2'h2)
            byte_cnt_q <= byte_cnt_q + 2'h1;
          if (byte_cnt_q == 2'h0)
            cmd_q <= rx_byte;
          else if (byte_cnt_q == 2'h1)
          begin
            addr_q  <= rx_byte;
            tx_sh_q <= reg_read(rx_byte);
          end
          else
          begin
            if (cmd_q == `SGC_CMD_WRITE)
            begin
              wr_stb_q  <= 1'b1;
              wr_addr_q <= addr_q;
              wr_data_q <= rx_byte;
            end
            addr_q  <= addr_q + 8'h01;
            tx_sh_q <= reg_read(addr_q + 8'h01);
          end
        end
      end
      else if (sck_fall)
      begin
        spi_miso <= tx_sh_q[7];
        tx_sh_q  <= {tx_sh_q[6:0], 1'b0};
      end
    end
  end

  // ****************************************
  // Control outputs
  // ****************************************
  logic          link_fall;
  logic [PORTS-1:0] link_prev_q;
  logic [CW-1:0] age_cnt_q;
  assign link_fall = |(link_prev_q & ~link_up);

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      switch_run          <= `SGC_RUN_RST;
      interop_backoff     <= 1'b0;
      soft_reset          <= 1'b0;
      rx_accept           <= 1'b0;
      interop_drop_select <= 1'b0;
      flush_learned       <= 1'b0;
      flush_port_mask     <= '0;
      flush_all           <= 1'b0;
      flush_static        <= 1'b0;
    end
    else if (clk_en)
    begin
      switch_run          <= run_q;
      interop_backoff     <= backoff_q;
      soft_reset          <= srst_q;
      rx_accept           <= run_q & ~srst_q;
      interop_drop_select <= dropsel_q;
      flush_learned       <= fldyn_q;
      flush_port_mask     <= fldyn_q ? learn_disable : '0;
      flush_all           <= fldyn_q & (&learn_disable);
      flush_static        <= flsta_q;
    end
  end

  // Frame drop decision; cleared with the data path
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      frame_drop <= 1'b0;
    else if (clk_en)
    begin
      if (srst_q)
        frame_drop <= 1'b0;
      else if (dropsel_q)
        frame_drop <= frame_in.valid &
          (frame_in.type_len == `SGC_PAUSE_TYPE ||
           frame_in.dest == `SGC_PAUSE_DA);
      else
        frame_drop <= frame_in.valid & frame_in.is_flow_ctl;
    end
  end

  // One fast aging window per link loss, then back to normal aging
  always_ff @(posedge sys_clk)
  begin
    if (reset || (clk_en && srst_q))
    begin
      link_prev_q <= '0;
      age_cnt_q   <= '0;
      fast_age    <= 1'b0;
      age_all     <= 1'b0;
    end
    else if (clk_en)
    begin
      link_prev_q <= link_up;
      age_all     <= lnkage_q & link_fall;
      if (lnkage_q && link_fall)
      begin
        age_cnt_q <= CW'(FAST_AGE_CYC - 1);
        fast_age  <= 1'b1;
      end
      else if (age_cnt_q != '0)
        age_cnt_q <= age_cnt_q - 1'b1;
      else
        fast_age <= 1'b0;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset || !clk_en);

  sequence wr_gctl0;
    wr_stb_q && wr_addr_q == `SGC_OFS_GCTL0;
  endsequence

  chk_run_follow: assert property (
    wr_stb_q && wr_addr_q == `SGC_OFS_ID_RUN ##1 clk_en ##1 clk_en
      |-> switch_run == $past(wr_data_q[0], 2))
    else $error("run output does not follow write");
  chk_backoff_sel: assert property (
    wr_gctl0 ##1 clk_en ##1 clk_en
      |-> interop_backoff == $past(wr_data_q[7], 2))
    else $error("back-off select does not follow write");
  chk_srst_out: assert property (
    soft_reset |-> !frame_drop)
    else $error("data path not held in soft reset");
  chk_cfg_kept: assert property (
    srst_q && !wr_stb_q |=> $stable(dropsel_q) && $stable(run_q))
    else $error("configuration changed by soft reset");
  chk_rx_stop: assert property (
    soft_reset |-> !rx_accept)
    else $error("frames accepted in soft reset");
  chk_flush_sc: assert property (
    fldyn_q && !wr_stb_q |=> !fldyn_q ##1 !flush_learned)
    else $error("learned flush bit does not self-clear");
  chk_flush_mask: assert property (
    flush_port_mask != '0 |-> flush_learned)
    else $error("port flush outside a flush");
  chk_flush_sta: assert property (
    flsta_q |=> flush_static)
    else $error("static flush not raised");
  chk_pause_drop: assert property (
    dropsel_q && !srst_q && frame_in.valid &&
    frame_in.type_len == `SGC_PAUSE_TYPE |=> frame_drop)
    else $error("pause type frame not dropped");
  chk_flow_drop: assert property (
    !dropsel_q && !srst_q && frame_in.valid && !frame_in.is_flow_ctl
    |=> !frame_drop)
    else $error("non flow-control frame dropped");
  chk_fast_age: assert property (
    !fast_age ##1 fast_age |-> age_cnt_q == CW'(FAST_AGE_CYC - 1))
    else $error("fast aging window length wrong");
  chk_age_all: assert property (
    lnkage_q && !srst_q && link_fall |=> age_all && fast_age)
    else $error("unplug did not age out table");
endmodule : sgc_regs

// File: verif/switch_global_control_regs_test.sv
`timescale 1ns/10ps
`include "sgc_defs.svh"
module switch_global_control_regs_test;
  import sgc_pkg::*;
  logic        sys_clk, reset, spi_miso, spi_miso_oe, frame_drop;
  logic        switch_run, interop_backoff, soft_reset, rx_accept;
  logic        flush_learned, flush_all, flush_static, fast_age, age_all;
  logic        interop_drop_select, v_q, sel_m, srst_m, clk_en;
  logic [3:0]  link_up, learn_disable, flush_port_mask;
  logic [3:0]  mask_seen = '0;
  logic [7:0]  rd_byte;
  logic [31:0] rng = 32'hF9ED;
  logic [7:0]  exp_q[$];
  logic        drop_q[$];
  sgc_spi_in_t spi_in;
  sgc_frame_t  frame_in;
  event        rd_ev;
  int n_fail = 0, n_checks = 0, n_fl = 0, n_fa = 0, n_fs = 0;
  int n_age = 0, n_fast = 0;

  // Identity codes are arbitrary values
  sgc_regs #(.FAST_AGE_CYC(8), .FAMILY_CODE(8'h3C), .PART_CODE(4'h9),
             .REV_CODE(3'h2)) i_dut (
    .sys_clk             (sys_clk),
    .reset               (reset),
    .clk_en              (clk_en),
    .spi_in              (spi_in),
    .spi_miso            (spi_miso),
    .spi_miso_oe         (spi_miso_oe),
    .link_up             (link_up),
    .learn_disable       (learn_disable),
    .frame_in            (frame_in),
    .frame_drop          (frame_drop),
    .switch_run          (switch_run),
    .interop_backoff     (interop_backoff),
    .soft_reset          (soft_reset),
    .rx_accept           (rx_accept),
    .flush_learned       (flush_learned),
    .flush_port_mask     (flush_port_mask),
    .flush_all           (flush_all),
    .flush_static        (flush_static),
    .interop_drop_select (interop_drop_select),
    .fast_age            (fast_age),
    .age_all             (age_all)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  function logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : next_rand

  task chk_val(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val

  task chk_cnt(input int got, input int exp);
    n_checks++;
    if (got != exp)
    begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_cnt

  task print_verdict();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick

  // Half period of 8 cycles leaves room for the 3-flop sync
  task sbyte(input logic [7:0] wb, output logic [7:0] rb);
    for (int i = 7; i >= 0; i--)
    begin
      spi_in.mosi = wb[i];
      tick(8);
      spi_in.sck = 1'b1;
      rb[i] = spi_miso;
      tick(8);
      spi_in.sck = 1'b0;
    end
  endtask : sbyte

  task xfer(input logic [7:0] cmd, adr, dat, output logic [7:0] rb);
    logic [7:0] junk;
    spi_in.cs_n = 1'b0;
    tick(4);
    sbyte(cmd, junk);
    chk_val({7'h00, spi_miso_oe}, 8'h01);
    sbyte(adr, junk);
    sbyte(dat, rb);
    tick(4);
    spi_in.cs_n = 1'b1;
    tick(12);
    chk_val({7'h00, spi_miso_oe}, 8'h00);
  endtask : xfer

  task wr(input logic [7:0] adr, dat);
    logic [7:0] junk;
    xfer(`SGC_CMD_WRITE, adr, dat, junk);
  endtask : wr

  task rd(input logic [7:0] adr, exp);
    exp_q.push_back(exp);
    xfer(`SGC_CMD_READ, adr, 8'h00, rd_byte);
    -> rd_ev;
  endtask : rd

  task frm(input logic [15:0] tl, input logic [47:0] da, input logic fc);
    drop_q.push_back(!srst_m && (sel_m ? (tl == `SGC_PAUSE_TYPE
                     || da == `SGC_PAUSE_DA) : fc));
    frame_in = '{1'b1, tl, da, fc};
    tick(1);
    frame_in.valid = 1'b0;
    tick(2);
  endtask : frm

  // Pause type, pause address, both without flag, then two random headers with flag set
  task frames();
    logic [31:0] r;
    for (int k = 0; k < 4; k++)
    begin
      r = next_rand();
      frm(k == 0 ? `SGC_PAUSE_TYPE : r[15:0] & 16'h7FFF,
          k == 1 ? `SGC_PAUSE_DA : {16'h0000, r}, k[1]);
    end
  endtask : frames

  task note_end(input string s);
    $display("Test %s ended", s);
  endtask : note_end

  // ****************************************
  // Output monitors
  // ****************************************
  always @(rd_ev) chk_val(rd_byte, exp_q.pop_front());

  always @(posedge sys_clk)
  begin
    if (v_q === 1'b1)
      chk_val({7'h00, frame_drop}, {7'h00, drop_q.pop_front()});
    v_q <= frame_in.valid;
    if (flush_learned === 1'b1)
      mask_seen <= mask_seen | flush_port_mask;
    n_fl   += (flush_learned === 1'b1);
    n_fa   += (flush_all === 1'b1);
    n_fs   += (flush_static === 1'b1);
    n_age  += (age_all === 1'b1);
    n_fast += (fast_age === 1'b1);
  end

  initial
  begin
    // About twice the expected run of some 10k cycles
    #400_000;
    n_fail++;
    print_verdict();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    reset = 1'b1;
    clk_en = 1'b1;
    spi_in = '{1'b1, 1'b0, 1'b0};
    frame_in = '0;
    link_up = 4'hF;
    learn_disable = 4'h0;
    sel_m = 1'b0;
    srst_m = 1'b0;
    tick(16);
    reset = 1'b0;
    tick(8);
    chk_val({7'h00, switch_run}, 8'h01);
    rd(8'h00, 8'h3C);
    rd(8'h01, 8'h95);
    rd(8'h02, 8'h0C);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h3C);
    wr(8'h05, 8'hFF);
    rd(8'h05, 8'h00);
    note_end("reset");
    wr(8'h01, 8'h00);
    chk_val({switch_run, rx_accept}, 8'h00);
    rd(8'h01, 8'h94);
    wr(8'h01, 8'h01);
    chk_val({switch_run, rx_accept}, 8'h03);
    note_end("run");
    frames();
    wr(8'h02, 8'h8E);
    sel_m = 1'b1;
    chk_val({interop_backoff, interop_drop_select}, 8'h03);
    rd(8'h02, 8'h8E);
    frames();
    note_end("drop");
    wr(8'h02, 8'h4E);
    srst_m = 1'b1;
    chk_val({soft_reset, rx_accept}, 8'h02);
    frames();
    rd(8'h02, 8'h4E);
    rd(8'h01, 8'h95);
    wr(8'h02, 8'h0C);
    srst_m = 1'b0;
    sel_m = 1'b0;
    chk_val({soft_reset, rx_accept}, 8'h01);
    frames();
    note_end("soft reset");
    learn_disable = 4'h5;
    wr(8'h02, 8'h2C);
    chk_cnt(n_fl, 1);
    chk_val({4'h0, mask_seen}, 8'h05);
    chk_cnt(n_fa, 0);
    rd(8'h02, 8'h0C);
    learn_disable = 4'hF;
    wr(8'h02, 8'h2C);
    chk_cnt(n_fa, 1);
    wr(8'h02, 8'h1C);
    chk_cnt(n_fs, 1);
    rd(8'h02, 8'h0C);
    note_end("flush");
    wr(8'h02, 8'h0D);
    link_up = 4'hB;
    tick(20);
    chk_cnt(n_age, 1);
    chk_cnt(n_fast, 8);
    link_up = 4'hF;
    wr(8'h02, 8'h0C);
    link_up = 4'hE;
    tick(20);
    chk_cnt(n_age + n_fast, 9);
    note_end("link aging");
    // Ten frozen edges stretch the eight-cycle window to eighteen
    link_up = 4'hF;
    wr(8'h02, 8'h0D);
    link_up = 4'hE;
    tick(3);
    clk_en = 1'b0;
    tick(10);
    clk_en = 1'b1;
    tick(20);
    chk_cnt(n_fast, 26);
    chk_cnt(n_age, 2);
    note_end("freeze");
    print_verdict();
  end
endmodule : switch_global_control_regs_test
